// *** sram_cycle_pkg.sv ***
// Constants for the static cycle sequencer and DRAM address multiplexer.
// Assumes one core clock; the bus clock is derived from it by halving.
package sram_cycle_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int ADDR_W = 24;
    localparam int DATA_W = 32;
    localparam int LANE_W = 4;
    localparam int WAIT_W = 6;
    localparam int BEAT_W = 4;
    localparam int MUX_PINS = 14;

    // ****************************************
    // Timing
    // ****************************************
    localparam logic [5:0] ASYNC_MIN_WAIT = 6'h01;

    // ****************************************
    // Memory width codes
    // ****************************************
    localparam logic [1:0] WIDTH_8 = 2'h0;
    localparam logic [1:0] WIDTH_16 = 2'h1;
    localparam logic [1:0] WIDTH_32 = 2'h2;

    // ****************************************
    // Multiplexer field positions (8-bit base)
    // ****************************************
    localparam int M0_ROW_BASE = 9;
    localparam int M0_LOW_PINS = 9;
    localparam int M0_HI_PIN = 11;
    localparam int M0_ROW_HI_BIT = 18;
    localparam int M0_COL_HI_BIT = 19;
    localparam int M1_ROW_BASE = 8;
    localparam int M1_ZERO_PIN = 11;
    localparam int M1_PIN9_BIT8 = 20;
    localparam int M1_PIN8_BIT8 = 19;

    // ****************************************
    // Sequencer states
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_S_LEAD = 3'b001,
        ST_S_RUN = 3'b010,
        ST_S_TAIL = 3'b011,
        ST_A_LEAD = 3'b100,
        ST_A_RUN = 3'b101,
        ST_A_REL = 3'b110,
        ST_A_GAP = 3'b111
    } seq_state_e;

endpackage

// *** static_cycle_and_dram_addr_mux.sv ***
// Static memory cycle sequencer with internal DRAM address multiplexer.
// Assumes inputs synchronous to i_core_clk; the bus clock is i_core_clk / 2.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Synchronous cycles referenced to bus clock rising edge
// - Sync: strobes on falling, others on rising; o_addr and o_data load on the falling edge that asserts the strobes
// - Sync: strobe active one falling edge before select
// - Sync: strobe held until falling edge after deselect
// - Sync: ack low at rising edge ends cycle
// - Asynchronous cycles always have at least one wait
// - Async strobes lie inside chip select low
// - Async: lanes, strobes fall after select asserts
// - Async: strobes rise on falling edge after ack
// - Async: ack edge samples read, holds write data
// - Burst transfers for reads and writes
// - Global and per-select bits choose multiplexer
// - Internal mux drives low fourteen address pins
// - Lowest mux pin follows memory width
// - Per-select bit picks mux mode 0 or 1
// - Mode 0 row and column bit placement
// - Mode 1 row bits, upper pins 12 and 13 carry bits 20 and 21
// - Mode 1 column: top three pins zero
// - Mode 1 column low bits placement
// - Wait field first beat, burst field later beats
module static_cycle_and_dram_addr_mux (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_req,
    input wire logic i_write,
    input wire logic i_burst,
    input wire logic [23:0] i_addr,
    input wire logic [3:0] i_byte_en,
    input wire logic [31:0] i_wdata,
    input wire logic i_sync_mode,
    input wire logic [5:0] i_wait_states,
    input wire logic [3:0] i_burst_beat_cycles,
    input wire logic [1:0] i_mem_width,
    input wire logic i_dram_sel,
    input wire logic i_dram_col,
    input wire logic i_external_mux_select,
    input wire logic i_mux_indicator_force,
    input wire logic i_per_cs_external_mux,
    input wire logic i_mux_mode_select,
    input wire logic i_transfer_ack_n,
    input wire logic [31:0] i_data,
    output logic o_bus_clk,
    output logic o_cs_n,
    output logic o_oe_n,
    output logic o_we_n,
    output logic [3:0] o_byte_lane_n,
    output logic [23:0] o_addr,
    output logic [31:0] o_data,
    output logic o_data_oe,
    output logic [31:0] o_rdata,
    output logic o_ack,
    output logic o_busy
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic phase;
        logic bclk;
        sram_cycle_pkg::seq_state_e st;
        logic cs_n;
        logic oe_n;
        logic we_n;
        logic [3:0] lane_n;
        logic [3:0] lane_en;
        logic [23:0] addr;
        logic [23:0] laddr;
        logic [31:0] dout;
        logic doe;
        logic [31:0] rdata;
        logic ack;
        logic [5:0] wcnt;
        logic write;
        logic sync;
        logic more;
        logic mode1;
        logic internal;
        logic dram;
        logic col;
        logic [1:0] width;
        logic [3:0] beat;
    } ctl_s;

    ctl_s s_q;
    ctl_s s_d;
    logic rise_en;
    logic fall_en;
    logic ack_seen;
    logic [23:0] step;

    // ****************************************
    // DRAM address multiplexer
    // ****************************************
    function automatic logic [23:0] mux_addr(input logic [23:0] a, input logic [1:0] w,
                                             input logic m1, input logic col);
        logic [23:0] r;
        int s;
        r = a;
        s = int'(w);
        r[13:0] = 14'h0000;
        if (!m1) begin
            for (int j = 0; j < sram_cycle_pkg::M0_LOW_PINS; j++) begin
                r[s + j] = col ? a[s + j] : a[sram_cycle_pkg::M0_ROW_BASE + s + j];
            end
            r[sram_cycle_pkg::M0_HI_PIN + s] = col ? a[sram_cycle_pkg::M0_COL_HI_BIT + s]
                                                   : a[sram_cycle_pkg::M0_ROW_HI_BIT + s];
        end else begin
            for (int j = 0; j < sram_cycle_pkg::MUX_PINS; j++) begin
                if (j >= s) begin
                    if (!col) begin
                        r[j] = a[sram_cycle_pkg::M1_ROW_BASE + j];
                    end else if (j >= sram_cycle_pkg::M1_ZERO_PIN) begin
                        r[j] = 1'b0;
                    end else if (s == 0 && j == 9) begin
                        r[j] = a[sram_cycle_pkg::M1_PIN9_BIT8];
                    end else if (s == 0 && j == 8) begin
                        r[j] = a[sram_cycle_pkg::M1_PIN8_BIT8];
                    end else begin
                        r[j] = a[j];
                    end
                end
            end
        end
        return r;
    endfunction

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_d = s_q;
        rise_en = !s_q.phase;
        fall_en = s_q.phase;
        ack_seen = rise_en && (s_q.wcnt == 6'h00) && !i_transfer_ack_n;
        step = 24'h00_0001 << s_q.width;
        s_d.phase = !s_q.phase;
        s_d.bclk = rise_en;
        s_d.ack = 1'b0;
        if (rise_en && s_q.st != sram_cycle_pkg::ST_IDLE) begin
            s_d.col = i_dram_col;
            s_d.addr = (s_q.dram && s_q.internal) ?
                       mux_addr(s_q.laddr, s_q.width, s_q.mode1, i_dram_col) : s_q.laddr;
        end
        case (s_q.st)
            sram_cycle_pkg::ST_IDLE: begin
                if (i_req && ((i_sync_mode && fall_en) || (!i_sync_mode && rise_en))) begin
                    s_d.laddr = i_addr;
                    s_d.write = i_write;
                    s_d.sync = i_sync_mode;
                    s_d.lane_en = i_byte_en;
                    s_d.dout = i_wdata;
                    s_d.width = i_mem_width;
                    s_d.beat = i_burst_beat_cycles;
                    s_d.dram = i_dram_sel;
                    s_d.col = i_dram_col;
                    s_d.mode1 = i_mux_mode_select;
                    s_d.internal = i_mux_indicator_force ||
                                   (!i_external_mux_select && !i_per_cs_external_mux);
                    s_d.addr = (i_dram_sel && s_d.internal) ?
                               mux_addr(i_addr, i_mem_width, i_mux_mode_select, i_dram_col) : i_addr;
                    if (i_sync_mode) begin
                        s_d.wcnt = i_wait_states;
                        s_d.oe_n = i_write;
                        s_d.we_n = !i_write;
                        s_d.st = sram_cycle_pkg::ST_S_LEAD;
                    end else begin
                        s_d.wcnt = (i_wait_states < sram_cycle_pkg::ASYNC_MIN_WAIT) ?
                                   sram_cycle_pkg::ASYNC_MIN_WAIT : i_wait_states;
                        s_d.cs_n = 1'b0;
                        s_d.doe = i_write;
                        s_d.st = sram_cycle_pkg::ST_A_LEAD;
                    end
                end
            end
            sram_cycle_pkg::ST_S_LEAD: begin
                if (rise_en) begin
                    s_d.cs_n = 1'b0;
                    s_d.lane_n = ~s_q.lane_en;
                    s_d.doe = s_q.write;
                    s_d.st = sram_cycle_pkg::ST_S_RUN;
                end
            end
            sram_cycle_pkg::ST_S_RUN: begin
                if (rise_en && s_q.wcnt != 6'h00) begin
                    s_d.wcnt = s_q.wcnt - 6'h01;
                end else if (ack_seen) begin
                    s_d.ack = 1'b1;
                    s_d.rdata = s_q.write ? s_q.rdata : i_data;
                    if (i_burst) begin
                        s_d.laddr = s_q.laddr + step;
                        s_d.dout = i_wdata;
                        s_d.wcnt = {2'h0, s_q.beat};
                    end else begin
                        s_d.cs_n = 1'b1;
                        s_d.lane_n = 4'hF;
                        s_d.doe = 1'b0;
                        s_d.st = sram_cycle_pkg::ST_S_TAIL;
                    end
                end
            end
            sram_cycle_pkg::ST_S_TAIL: begin
                s_d.oe_n = 1'b1;
                s_d.we_n = 1'b1;
                s_d.st = sram_cycle_pkg::ST_IDLE;
            end
            sram_cycle_pkg::ST_A_LEAD: begin
                if (fall_en) begin
                    s_d.oe_n = s_q.write;
                    s_d.we_n = !s_q.write;
                    s_d.lane_n = ~s_q.lane_en;
                    s_d.st = sram_cycle_pkg::ST_A_RUN;
                end
            end
            sram_cycle_pkg::ST_A_RUN: begin
                if (rise_en && s_q.wcnt != 6'h00) begin
                    s_d.wcnt = s_q.wcnt - 6'h01;
                end else if (ack_seen) begin
                    s_d.ack = 1'b1;
                    s_d.rdata = s_q.write ? s_q.rdata : i_data;
                    s_d.more = i_burst;
                    s_d.st = sram_cycle_pkg::ST_A_REL;
                end
            end
            sram_cycle_pkg::ST_A_REL: begin
                s_d.oe_n = 1'b1;
                s_d.we_n = 1'b1;
                s_d.lane_n = 4'hF;
                s_d.st = sram_cycle_pkg::ST_A_GAP;
            end
            sram_cycle_pkg::ST_A_GAP: begin
                if (s_q.more) begin
                    s_d.laddr = s_q.laddr + step;
                    s_d.dout = i_wdata;
                    s_d.wcnt = (s_q.beat == 4'h0) ? sram_cycle_pkg::ASYNC_MIN_WAIT
                                                  : {2'h0, s_q.beat};
                    s_d.st = sram_cycle_pkg::ST_A_LEAD;
                end else begin
                    s_d.cs_n = 1'b1;
                    s_d.doe = 1'b0;
                    s_d.st = sram_cycle_pkg::ST_IDLE;
                end
            end
            default: begin
                s_d.st = sram_cycle_pkg::ST_IDLE;
            end
        endcase
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q <= '0;
            s_q.cs_n <= 1'b1;
            s_q.oe_n <= 1'b1;
            s_q.we_n <= 1'b1;
            s_q.lane_n <= 4'hF;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_bus_clk = s_q.bclk;
    assign o_cs_n = s_q.cs_n;
    assign o_oe_n = s_q.oe_n;
    assign o_we_n = s_q.we_n;
    assign o_byte_lane_n = s_q.lane_n;
    assign o_addr = s_q.addr;
    assign o_data = s_q.dout;
    assign o_data_oe = s_q.doe;
    assign o_rdata = s_q.rdata;
    assign o_ack = s_q.ack;
    assign o_busy = (s_q.st != sram_cycle_pkg::ST_IDLE);

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    chk_sync_cs_edge: assert property ($changed(o_cs_n) && s_q.sync |-> $rose(o_bus_clk))
        else $error("sync select moved off rising edge");
    chk_sync_strobe_edge: assert property (s_q.sync && $changed(o_oe_n) |-> $fell(o_bus_clk))
        else $error("sync strobe moved off falling edge");
    chk_sync_strobe_lead: assert property ($fell(o_cs_n) && s_q.sync |-> $past(!(o_oe_n && o_we_n)))
        else $error("sync strobe not active before select");
    chk_sync_strobe_tail: assert property ($rose(o_cs_n) && s_q.sync |-> !(o_oe_n && o_we_n) ##1 (o_oe_n && o_we_n))
        else $error("sync strobe not held past deselect");
    chk_ack_sample: assert property (o_ack |-> $past(i_transfer_ack_n) == 1'b0 && o_bus_clk)
        else $error("ack without low acknowledge at rising edge");
    chk_async_min_wait: assert property ($fell(o_cs_n) && !s_q.sync |-> !o_ack [*4])
        else $error("async cycle shorter than one wait");
    chk_async_inside: assert property (!s_q.sync && !(o_oe_n && o_we_n) |-> !o_cs_n)
        else $error("async strobe outside select");
    chk_async_fall: assert property ($fell(o_cs_n) && !s_q.sync |=> !(o_oe_n && o_we_n) && !o_bus_clk)
        else $error("async strobe not at first falling edge");
    chk_async_release: assert property (o_ack && !s_q.sync |=> o_oe_n && o_we_n && (&o_byte_lane_n))
        else $error("async strobes not released after ack");
    chk_mode1_col_zero: assert property (s_q.dram && s_q.internal && s_q.mode1 && s_q.col
                                         && o_busy |-> o_addr[13:11] == 3'h0)
        else $error("mode 1 column top pins not zero");
    chk_mux_hold: assert property (o_busy && $past(o_busy) |-> $stable(s_q.mode1) && $stable(s_q.internal))
        else $error("mux setting changed mid access");

    cov_sync_read: cover property (s_q.sync && !s_q.write && o_ack);
    cov_async_write: cover property (!s_q.sync && s_q.write && o_ack);
    cov_burst: cover property (o_ack ##[1:40] o_ack);
    cov_mode1_col: cover property (s_q.dram && s_q.mode1 && s_q.col && o_busy);

endmodule
`default_nettype wire

// *** static_mem_model.sv ***
// Behavioural far-side static memory or peripheral for the cycle sequencer bench.
// Assumes it sees the design's pins and is clocked by the bench's core clock.
`timescale 1ns/1ps
`default_nettype none
module static_mem_model (
    input wire logic i_core_clk,
    input wire logic i_cs_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    input wire logic [23:0] i_addr,
    input wire logic [31:0] i_data,
    input wire logic i_data_oe,
    input wire logic [7:0] i_ack_delay,
    output logic o_transfer_ack_n,
    output logic [31:0] o_data,
    output logic [31:0] o_wr_data
);
    int wait_cnt;
    initial begin
        o_transfer_ack_n = 1'b1;
        o_data = 32'h0000_0000;
        o_wr_data = 32'h0000_0000;
        wait_cnt = 0;
    end
    // ****************************************
    // Acknowledge, read data and write capture
    // ****************************************
    always @(posedge i_core_clk) begin
        #1;
        if (i_cs_n) begin
            wait_cnt = 0;
            o_transfer_ack_n = 1'b1;
        end else begin
            if (wait_cnt >= int'(i_ack_delay)) begin
                o_transfer_ack_n = 1'b0;
            end
            wait_cnt++;
        end
        // Released data lines toggle so stale values never match
        o_data = i_oe_n ? ~o_data : {8'hc3, i_addr};
        if (!i_we_n && i_data_oe && !o_transfer_ack_n) begin
            o_wr_data = i_data;
        end
    end
endmodule
`default_nettype wire

// *** static_cycle_and_dram_addr_mux_tb.sv ***
// Self-checking bench for the static cycle sequencer and DRAM address multiplexer.
// Assumes static_mem_model answers on the far side of the pins.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
    $display("unexpected at %0t: got %h exp %h", $time, (a), (b)); end end
module static_cycle_and_dram_addr_mux_tb;
    logic clk = 1'b0, rst = 1'b1, i_req = 1'b0, i_write = 1'b0, i_burst = 1'b0;
    logic [23:0] i_addr = 24'h00_0000;
    logic [3:0] i_byte_en = 4'hf, i_bbc = 4'h1;
    logic [31:0] i_wdata = 32'h0000_0000, i_data, o_data, o_rdata, wr_seen;
    logic i_sync_mode = 1'b1, i_dram_sel = 1'b0, i_dram_col = 1'b0, ext = 1'b0, frc = 1'b0;
    logic pcs = 1'b0, i_mode = 1'b0, ack_n, o_bus_clk, o_cs_n, o_oe_n, o_we_n;
    logic o_data_oe, o_ack, o_busy;
    logic [5:0] i_wait = 6'h00;
    logic [1:0] i_width = 2'h0;
    logic [3:0] o_lanes_n;
    logic [23:0] o_addr;
    logic [7:0] delay = 8'h00;
    int errors = 0, total_checks = 0, n;
    always #5 clk = ~clk;
    static_cycle_and_dram_addr_mux i_static_cycle_and_dram_addr_mux (.i_core_clk(clk),
        .i_rst(rst), .i_req(i_req), .i_write(i_write), .i_burst(i_burst), .i_addr(i_addr),
        .i_byte_en(i_byte_en), .i_wdata(i_wdata), .i_sync_mode(i_sync_mode),
        .i_wait_states(i_wait), .i_burst_beat_cycles(i_bbc), .i_mem_width(i_width),
        .i_dram_sel(i_dram_sel), .i_dram_col(i_dram_col), .i_external_mux_select(ext),
        .i_mux_indicator_force(frc), .i_per_cs_external_mux(pcs), .i_mux_mode_select(i_mode),
        .i_transfer_ack_n(ack_n), .i_data(i_data), .o_bus_clk(o_bus_clk), .o_cs_n(o_cs_n),
        .o_oe_n(o_oe_n), .o_we_n(o_we_n), .o_byte_lane_n(o_lanes_n), .o_addr(o_addr),
        .o_data(o_data), .o_data_oe(o_data_oe), .o_rdata(o_rdata), .o_ack(o_ack),
        .o_busy(o_busy));
    static_mem_model i_static_mem_model (.i_core_clk(clk), .i_cs_n(o_cs_n), .i_oe_n(o_oe_n),
        .i_we_n(o_we_n), .i_addr(o_addr), .i_data(o_data), .i_data_oe(o_data_oe),
        .i_ack_delay(delay), .o_transfer_ack_n(ack_n), .o_data(i_data), .o_wr_data(wr_seen));
    // ****************************************
    // Closing, watchdog and pin monitor
    // ****************************************
    task automatic stop_test();
        if (errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #200_000;
        errors++;
        stop_test();
    end
    always @(posedge clk) begin
        #2;
        if (!i_sync_mode && (!o_oe_n || !o_we_n)) begin
            `CHK(o_cs_n, 1'b0)
        end
        if (!i_sync_mode && !o_we_n) begin
            `CHK(o_lanes_n, ~i_byte_en)
        end
    end
    // ****************************************
    // Access helpers
    // ****************************************
    task automatic start(input logic s, input logic wr, input int beats,
                         input logic [23:0] a, input logic [31:0] d);
        i_sync_mode = s;
        i_write = wr;
        i_addr = a;
        i_wdata = d;
        i_burst = beats > 1;
        i_req = 1'b1;
        n = 0;
        while (!o_busy && n < 50) begin
            @(posedge clk);
            #1;
            n++;
        end
        i_req = 1'b0;
        n = 0;
    endtask
    // Waits for every beat, checks read data per beat, returns first ack cycle
    task automatic finish(input int beats, input logic [23:0] a, input logic chk_rd,
                          output int first);
        int acks;
        acks = 0;
        first = 0;
        while ((acks < beats || o_busy) && n < 400) begin
            @(posedge clk);
            #1;
            n++;
            if (o_ack === 1'b1) begin
                if (acks == 0) first = n;
                if (chk_rd) `CHK(o_rdata, {8'hc3, a + (24'(acks) << i_width)})
                acks++;
                if (acks == beats - 1) i_burst = 1'b0;
            end
        end
        if (n >= 400) begin
            errors++;
            stop_test();
        end
    endtask
    // ****************************************
    // Address multiplexer expectation
    // ****************************************
    function automatic logic [47:0] mux_exp(input logic m, input int w, input logic c,
                                            input logic [23:0] a);
        logic [23:0] v, k;
        v = {a[23:14], 14'h0000};
        k = 24'hff_c000;
        for (int p = 0; p < w; p++) k[p] = 1'b1;
        if (!m) begin
            for (int p = w; p < w + 9; p++) begin
                k[p] = 1'b1;
                v[p] = c ? a[p] : a[p + 9];
            end
            k[11 + w] = 1'b1;
            v[11 + w] = c ? a[19 + w] : a[18 + w];
        end else begin
            for (int p = w; p < 14; p++) begin
                k[p] = 1'b1;
                v[p] = !c ? a[p + 8] : (p > 10) ? 1'b0 : a[p];
            end
            if (c && w == 0) begin
                v[8] = a[19];
                v[9] = a[20];
            end
        end
        return {k, v};
    endfunction
    task automatic dram_case(input logic m, input int w, input logic e, input logic pc,
                             input logic f);
        logic [23:0] a;
        logic [47:0] x;
        int t;
        a = 24'h9a_5e3c ^ 24'(w * 24'h13_1357);
        i_dram_sel = 1'b1;
        i_mode = m;
        i_width = 2'(w);
        ext = e;
        pcs = pc;
        frc = f;
        i_dram_col = 1'b0;
        delay = 8'd60;
        i_wait = 6'h0a;
        start(1'b0, 1'b0, 1, a, 32'h0000_0000);
        for (int c = 0; c < 2; c++) begin
            repeat (8) @(posedge clk);
            #1;
            n += 8;
            x = (f || (!e && !pc)) ? mux_exp(m, w, c[0], a) : {24'hff_ffff, a};
            `CHK(o_addr & x[47:24], x[23:0])
            i_mode = ~m;
            i_dram_col = 1'b1;
        end
        finish(1, a, 1'b0, t);
        i_dram_sel = 1'b0;
        {ext, pcs, frc, i_mode, i_dram_col} = 5'b00000;
        delay = 8'h00;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic sync_timing();
        int t;
        i_wait = 6'h00;
        start(1'b1, 1'b0, 1, 24'h12_3454, 32'h0000_0000);
        finish(1, 24'h12_3454, 1'b1, t);
        `CHK(t, 3)
        start(1'b1, 1'b1, 1, 24'h00_0040, 32'hdead_beef);
        finish(1, 24'h00_0040, 1'b0, t);
        `CHK(wr_seen, 32'hdead_beef)
    endtask
    task automatic async_timing();
        int t;
        i_byte_en = 4'h5;
        for (int wt = 0; wt < 3; wt++) begin
            i_wait = 6'(wt);
            start(1'b0, 1'b1, 1, 24'h00_0100, 32'h0bad_f00d + 32'(wt));
            finish(1, 24'h00_0100, 1'b0, t);
            `CHK(t, (wt < 2) ? 4 : 6)
            `CHK(wr_seen, 32'h0bad_f00d + 32'(wt))
        end
        start(1'b0, 1'b0, 1, 24'h00_0abc, 32'h0000_0000);
        finish(1, 24'h00_0abc, 1'b1, t);
        i_byte_en = 4'hf;
    endtask
    task automatic bursts();
        int t;
        i_wait = 6'h01;
        i_width = 2'h1;
        start(1'b1, 1'b0, 3, 24'h00_2000, 32'h0000_0000);
        finish(3, 24'h00_2000, 1'b1, t);
        i_width = 2'h2;
        start(1'b0, 1'b0, 2, 24'h00_3000, 32'h0000_0000);
        finish(2, 24'h00_3000, 1'b1, t);
        i_width = 2'h0;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        `CHK({o_cs_n, o_busy, o_ack}, 3'b100)
        sync_timing();
        async_timing();
        bursts();
        for (int k = 0; k < 6; k++) dram_case(k[0], k / 2, 1'b0, 1'b0, 1'b0);
        dram_case(1'b1, 2, 1'b1, 1'b0, 1'b0);
        dram_case(1'b1, 1, 1'b0, 1'b1, 1'b0);
        dram_case(1'b0, 2, 1'b1, 1'b1, 1'b1);
        stop_test();
    end
endmodule
`default_nettype wire
